// ===== tb/core_model.sv
// processor-side model: apb master and peripheral access source
`timescale 1ns/1ps
module core_model (
    // clock
    input wire logic sys_clk_i,
    // apb master
    output logic psel_o = 1'b0,
    output logic penable_o = 1'b0,
    output logic pwrite_o = 1'b0,
    output logic [11:0] paddr_o = 12'h0,
    output logic [31:0] pwdata_o = 32'h0,
    input wire logic [31:0] prdata_i,
    input wire logic pready_i,
    input wire logic pslverr_i,
    // peripheral accesses
    output clk_gate_pkg::periph_acc_t periph_acc_o = '0,
    input wire logic bus_fault_i
);
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e,
        output logic ok);
        @(posedge sys_clk_i);
        psel_o <= 1'b1;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge sys_clk_i);
        penable_o <= 1'b1;
        ok = 1'b0;
        for (int n = 0; n < 16 && !ok; n++) begin
            @(posedge sys_clk_i);
            ok = pready_i;
        end
        r = prdata_i;
        e = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        // released lines must not keep showing the last value
        paddr_o <= ~a;
        pwdata_o <= ~d;
    endtask : apb
    task automatic touch(input logic [3:0] u, output logic f);
        @(posedge sys_clk_i);
        periph_acc_o <= {1'b1, u};
        @(posedge sys_clk_i);
        periph_acc_o <= '0;
        #1;
        f = bus_fault_i;
    endtask : touch
endmodule : core_model

// ===== tb/gate_props.sv
// port assertions for the sleep-mode clock gating block
`timescale 1ns/1ps
module gate_props #(
    parameter int ADDR_W = 12
) (
    // clock, reset and apb
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // modes, accesses and enables
    input wire logic sleep_req_i,
    input wire logic deep_sleep_req_i,
    input wire logic auto_clock_gating_en_i,
    input wire clk_gate_pkg::unit_en_t run_clock_gate_ctl2_i,
    input wire clk_gate_pkg::periph_acc_t periph_acc_i,
    input wire logic bus_fault_o,
    input wire clk_gate_pkg::unit_en_t unit_clk_en_o,
    input wire logic irq_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic [1:0] up_q;
    logic [9:0] en_w;
    logic setup_w;
    logic gated_w;
    assign en_w = unit_clk_en_o;
    assign setup_w = psel_i && !penable_i;
    assign gated_w = periph_acc_i.valid && periph_acc_i.unit < 4'ha
        && !en_w[periph_acc_i.unit];
    // the pipeline needs a few edges after reset to settle
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) up_q <= 2'h0;
        else if (up_q != 2'h3) up_q <= up_q + 2'h1;
    end
    chk_reset_zero: assert property (disable iff (1'b0)
        $rose(rst_n_i) |-> !pready_o && !irq_o && en_w == 10'h0)
        else $error("outputs not clear after reset");
    chk_decode_ok: assert property (setup_w && paddr_i == 12'h118
        |=> pready_o && !pslverr_o) else $error("register not decoded");
    chk_unmapped_err: assert property (setup_w && !(paddr_i inside
        {12'h118, 12'h180, 12'h184, 12'h188, 12'h18c})
        |=> pready_o && pslverr_o && prdata_o == 32'h0)
        else $error("unmapped access not refused");
    chk_rsvd_zero: assert property (pready_o && !pwrite_i
        && paddr_i == 12'h118 |-> (prdata_o & 32'hfffe_df00) == 32'h0)
        else $error("reserved bits read nonzero");
    chk_fault_gated: assert property (gated_w |=> bus_fault_o)
        else $error("gated access gave no fault");
    chk_no_fault: assert property (!gated_w |=> !bus_fault_o)
        else $error("fault without gated access");
    chk_run_set: assert property ((up_q == 2'h3
        && !auto_clock_gating_en_i && $stable(run_clock_gate_ctl2_i))[*3]
        |-> unit_clk_en_o == run_clock_gate_ctl2_i)
        else $error("run set not applied");
    chk_en_steady: assert property ((up_q == 2'h3 && !psel_i
        && !deep_sleep_req_i && $stable(deep_sleep_req_i)
        && $stable(sleep_req_i)
        && $stable(auto_clock_gating_en_i)
        && $stable(run_clock_gate_ctl2_i))[*3] |-> $stable(unit_clk_en_o))
        else $error("enables moved with inputs quiet");
    cover property (bus_fault_o);
    cover property (irq_o);
    cover property (pready_o && pslverr_o);
endmodule : gate_props
bind sleep_mode_clock_gating gate_props #(.ADDR_W(ADDR_W)) gate_props_i (
    .sys_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .prdata_o, .pready_o, .pslverr_o, .sleep_req_i, .deep_sleep_req_i,
    .auto_clock_gating_en_i, .run_clock_gate_ctl2_i, .periph_acc_i,
    .bus_fault_o, .unit_clk_en_o, .irq_o);

// ===== tb/sleep_mode_clock_gating_bench.sv
// self-checking bench for the sleep-mode clock gating block
`timescale 1ns/1ps
module sleep_mode_clock_gating_bench;
    logic clk;
    logic rst_n = 1'b0;
    logic sleep_req = 1'b0;
    logic deep_req = 1'b0;
    logic auto_en = 1'b0;
    clk_gate_pkg::unit_en_t run_set = '0;
    clk_gate_pkg::unit_en_t deep_set = '0;
    clk_gate_pkg::unit_en_t unit_en;
    clk_gate_pkg::periph_acc_t acc;
    logic psel, penable, pwrite, pready, pslverr, fault, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    int fails = 0;
    int compares = 0;
    int sleep_m = 0;
    sleep_mode_clock_gating sleep_mode_clock_gating_i (.sys_clk_i(clk),
        .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .pstrb_i(4'hf), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .sleep_req_i(sleep_req),
        .deep_sleep_req_i(deep_req), .auto_clock_gating_en_i(auto_en),
        .run_clock_gate_ctl2_i(run_set),
        .deepsleep_clock_gate_ctl2_i(deep_set), .periph_acc_i(acc),
        .bus_fault_o(fault), .unit_clk_en_o(unit_en), .irq_o(irq));
    core_model core_model_i (.sys_clk_i(clk), .psel_o(psel),
        .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
        .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready),
        .pslverr_i(pslverr), .periph_acc_o(acc), .bus_fault_i(fault));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic results();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : results
    task automatic check(input string n, input logic [31:0] e,
        input logic [31:0] s);
        compares++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic rw(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        logic ok;
        core_model_i.apb(w, a, d, r, e, ok);
        if (!ok) begin
            fails++;
            results();
        end
    endtask : rw
    // deep-sleep wins over sleep; auto gating off keeps the run set
    function automatic logic [9:0] exp_en();
        logic [31:0] s;
        s = sleep_m;
        if (auto_en && deep_req) return deep_set;
        if (auto_en && sleep_req) return {s[16], s[13], s[7:0]};
        return run_set;
    endfunction : exp_en
    initial begin
        logic [31:0] r;
        logic [31:0] d;
        logic e;
        logic f;
        logic [9:0] x;
        void'($urandom(32'h77ae));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rw(1'b0, 12'h118, 32'h0, r, e);
        check("reset value", 32'h0, r);
        rw(1'b0, 12'h11c, 32'h0, r, e);
        check("unmapped error", 32'h1, {31'h0, e});
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            d = $urandom;
            rw(1'b1, 12'h118, d, r, e);
            sleep_m = d & 32'h120ff;
            rw(1'b0, 12'h118, 32'h0, r, e);
            check("sleep reg", sleep_m, r);
            @(posedge clk);
            run_set <= 10'($urandom);
            deep_set <= 10'($urandom);
            auto_en <= i % 3 != 0;
            sleep_req <= i[0];
            deep_req <= i % 4 == 3;
            repeat (3) @(posedge clk);
            #1;
            x = exp_en();
            check("enables", {22'h0, x}, {22'h0, unit_en});
            for (int u = 0; u < 11; u++) begin
                core_model_i.touch(4'(u), f);
                check("fault", {31'h0, u < 10 && !x[u]}, {31'h0, f});
            end
        end
        $display("test modes done");
        @(posedge clk);
        auto_en <= 1'b1;
        sleep_req <= 1'b1;
        deep_req <= 1'b0;
        rw(1'b1, 12'h118, 32'h0, r, e);
        rw(1'b1, 12'h184, 32'h1, r, e);
        rw(1'b1, 12'h180, 32'h7, r, e);
        for (int k = 0; k < 3; k++) begin
            if (k == 2) rw(1'b1, 12'h184, 32'h0, r, e);
            if (k != 1) core_model_i.touch(4'h5, f);
            else rw(1'b1, 12'h180, 32'h1, r, e);
            repeat (3) @(posedge clk);
            #1;
            check("irq", {31'h0, k == 0}, {31'h0, irq});
        end
        rw(1'b0, 12'h188, 32'h0, r, e);
        check("fault unit", 32'h5, r);
        rw(1'b0, 12'h18c, 32'h0, r, e);
        check("mode info", 32'h2, r);
        sleep_req <= 1'b0;
        repeat (3) @(posedge clk);
        rw(1'b0, 12'h180, 32'h0, r, e);
        check("status", 32'h5, r);
        $display("test interrupt done");
        results();
    end
endmodule : sleep_mode_clock_gating_bench

// ===== verilog/clk_gate_pkg.sv
// types shared by the sleep-mode clock gating block
package clk_gate_pkg;

    // one enable per controlled unit, port a in bit 0
    typedef struct packed {
        logic usb;
        logic micro_dma;
        logic [7:0] port;
    } unit_en_t;

    typedef enum logic [2:0] {
        MODE_RUN = 3'b001,
        MODE_SLEEP = 3'b010,
        MODE_DEEP = 3'b100
    } power_mode_t;

    // a peripheral bus access: unit 0..7 ports, 8 micro-dma, 9 usb
    typedef struct packed {
        logic valid;
        logic [3:0] unit;
    } periph_acc_t;

endpackage : clk_gate_pkg

// ===== verilog/clk_gate_regs.svh
// register offsets, field positions and reset values of the gating block
`ifndef CLK_GATE_REGS_SVH
`define CLK_GATE_REGS_SVH

`define SYSCTL_BASE_ADDR 32'h400f_e000
`define SCG2_OFFSET 12'h118
`define INT_STATUS_OFFSET 12'h180
`define INT_MASK_OFFSET 12'h184
`define FAULT_INFO_OFFSET 12'h188
`define MODE_INFO_OFFSET 12'h18c

`define SCG2_RESET 32'h0000_0000
`define SCG2_WR_MASK 32'h0001_20ff
`define SCG2_USB_BIT 16
`define SCG2_DMA_BIT 13
`define SCG2_PORT_MSB 7
`define SCG2_PORT_LSB 0

`define INT_FAULT_BIT 0
`define INT_SLEEP_IN_BIT 1
`define INT_SLEEP_OUT_BIT 2
`define INT_WIDTH 3
`define INT_RESET 3'h0

`define UNIT_DMA_IDX 8
`define UNIT_USB_IDX 9
`define UNIT_COUNT 10

`endif

// ===== verilog/fault_check.sv
// flags accesses aimed at a unit whose clock is currently gated off
`timescale 1ns/1ps
`include "clk_gate_regs.svh"
module fault_check #(
    parameter int UNITS = `UNIT_COUNT
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // access and current enables
    input wire clk_gate_pkg::periph_acc_t acc_i,
    input wire logic [UNITS-1:0] eff_en_i,
    // fault pulse and faulting unit
    output logic fault_o,
    output logic [3:0] fault_unit_o
);
    logic hit_d;

    // unknown unit numbers are outside this block and never fault
    always_comb begin
        hit_d = 1'b0;
        if (acc_i.valid && (int'(acc_i.unit) < UNITS)) begin
            hit_d = !eff_en_i[acc_i.unit];
        end
    end

    // gated unit answers with a bus fault
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fault_o <= 1'b0;
        end else begin
            fault_o <= hit_d;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fault_unit_o <= 4'h0;
        end else if (hit_d) begin
            fault_unit_o <= acc_i.unit;
        end
    end
endmodule : fault_check

// ===== verilog/gate_select.sv
// per-unit selection of the effective clock enable from the three gate sets
`timescale 1ns/1ps
`include "clk_gate_regs.svh"
module gate_select #(
    parameter int UNITS = `UNIT_COUNT
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // gate sets and mode
    input wire clk_gate_pkg::power_mode_t mode_i,
    input wire logic auto_clock_gating_en_i,
    input wire logic [UNITS-1:0] run_en_i,
    input wire logic [UNITS-1:0] sleep_en_i,
    input wire logic [UNITS-1:0] deep_en_i,
    // registered enables for the clock gate cells
    output logic [UNITS-1:0] eff_en_o
);
    for (genvar i = 0; i < UNITS; i++) begin : g_unit
        logic sel_d;
        always_comb begin
            sel_d = run_en_i[i];
            // auto gating gates the sleep sets
            if (auto_clock_gating_en_i) begin
                // sleep set only in sleep mode
                if (mode_i == clk_gate_pkg::MODE_SLEEP) begin
                    sel_d = sleep_en_i[i];
                end else if (mode_i == clk_gate_pkg::MODE_DEEP) begin
                    sel_d = deep_en_i[i];
                end
            end
        end
        // enable is a flop so a latch-type gate never sees a glitch
        always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                eff_en_o[i] <= 1'b0;
            end else begin
                eff_en_o[i] <= sel_d;
            end
        end
    end
endmodule : gate_select

// ===== verilog/sleep_mode_clock_gating.sv
// sleep-mode clock gating register with apb access, mode and fault logic
`timescale 1ns/1ps
`include "clk_gate_regs.svh"
module sleep_mode_clock_gating #(
    parameter int ADDR_W = 12,
    parameter int UNITS = `UNIT_COUNT
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // power state requests and neighbouring gate sets, same clock
    input wire logic sleep_req_i,
    input wire logic deep_sleep_req_i,
    input wire logic auto_clock_gating_en_i,
    input wire clk_gate_pkg::unit_en_t run_clock_gate_ctl2_i,
    input wire clk_gate_pkg::unit_en_t deepsleep_clock_gate_ctl2_i,
    // peripheral bus access watch
    input wire clk_gate_pkg::periph_acc_t periph_acc_i,
    output logic bus_fault_o,
    // unit clock enables and interrupt
    output clk_gate_pkg::unit_en_t unit_clk_en_o,
    output logic irq_o
);
    logic [31:0] sleep_clock_gate_ctl2_q;
    logic [`INT_WIDTH-1:0] int_status_q;
    logic [`INT_WIDTH-1:0] int_mask_q;
    clk_gate_pkg::power_mode_t mode_q;
    clk_gate_pkg::power_mode_t mode_d;
    clk_gate_pkg::unit_en_t sleep_en;
    logic [UNITS-1:0] eff_en;
    logic fault;
    logic [3:0] fault_unit;
    logic setup_ph;
    logic wr_done;
    logic [31:0] rdata_d;
    logic hit_d;
    logic [31:0] wmask;
    logic sleep_in;
    logic sleep_out;
    logic [`INT_WIDTH-1:0] int_set;
    logic [`INT_WIDTH-1:0] int_pend;

    // decoded bus strobes and per-register read views
    logic acc_ph;
    logic wr_sleep;
    logic wr_status;
    logic wr_mask;
    logic [31:0] rd_sleep;
    logic [31:0] rd_status;
    logic [31:0] rd_mask;
    logic [31:0] rd_fault;
    logic [31:0] rd_mode;

    // ---------------- apb slave ----------------
    // answer is prepared in the setup cycle so every bus output is a flop;
    // this costs no wait state: pready is high through the access phase
    assign setup_ph = psel_i && !penable_i;
    // access edge of any transfer, the only edge at which a write lands
    assign acc_ph = psel_i && penable_i && pready_o;
    assign wr_done = acc_ph && pwrite_i && !pslverr_o;

    for (genvar b = 0; b < 4; b++) begin : g_strb
        assign wmask[8*b +: 8] = {8{pstrb_i[b]}};
    end

    // one decoded strobe per writable register
    assign wr_sleep = wr_done && (paddr_i == ADDR_W'(`SCG2_OFFSET));
    assign wr_status = wr_done && pstrb_i[0]
        && (paddr_i == ADDR_W'(`INT_STATUS_OFFSET));
    assign wr_mask = wr_done && pstrb_i[0]
        && (paddr_i == ADDR_W'(`INT_MASK_OFFSET));

    // read views; narrow registers are padded with zeros
    // reserved bits masked again on read
    assign rd_sleep = sleep_clock_gate_ctl2_q & `SCG2_WR_MASK;
    assign rd_status = {{(32-`INT_WIDTH){1'b0}}, int_status_q};
    assign rd_mask = {{(32-`INT_WIDTH){1'b0}}, int_mask_q};
    assign rd_fault = {28'h000_0000, fault_unit};
    assign rd_mode = {29'h0000_000, mode_q};

    always_comb begin
        rdata_d = 32'h0000_0000;
        hit_d = 1'b1;
        unique case (paddr_i)
            // sleep gating register at its offset
            ADDR_W'(`SCG2_OFFSET): begin
                rdata_d = rd_sleep;
            end
            ADDR_W'(`INT_STATUS_OFFSET): begin
                rdata_d = rd_status;
            end
            ADDR_W'(`INT_MASK_OFFSET): begin
                rdata_d = rd_mask;
            end
            ADDR_W'(`FAULT_INFO_OFFSET): begin
                rdata_d = rd_fault;
            end
            ADDR_W'(`MODE_INFO_OFFSET): begin
                rdata_d = rd_mode;
            end
            default: begin
                hit_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready_o <= 1'b0;
        end else begin
            pready_o <= setup_ph;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pslverr_o <= 1'b0;
        end else if (setup_ph) begin
            pslverr_o <= !hit_d;
        end else begin
            pslverr_o <= 1'b0;
        end
    end

    // read data only on reads, so a write leaves the bus quiet
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (setup_ph && !pwrite_i) begin
            prdata_o <= rdata_d;
        end else begin
            prdata_o <= 32'h0000_0000;
        end
    end

    // ---------------- sleep gating register ----------------
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sleep_clock_gate_ctl2_q <= `SCG2_RESET;
        end else if (wr_sleep) begin
            // reserved bits stay zero whatever is written
            sleep_clock_gate_ctl2_q <= (sleep_clock_gate_ctl2_q & ~wmask)
                | (pwdata_i & wmask & `SCG2_WR_MASK);
        end
    end

    assign sleep_en.usb = sleep_clock_gate_ctl2_q[`SCG2_USB_BIT];
    assign sleep_en.micro_dma = sleep_clock_gate_ctl2_q[`SCG2_DMA_BIT];
    // one bit per port, a in bit 0
    assign sleep_en.port =
        sleep_clock_gate_ctl2_q[`SCG2_PORT_MSB:`SCG2_PORT_LSB];

    // ---------------- power mode ----------------
    // one-hot power state
    // deep-sleep wins when both requests are high; every state reaches
    // every other in one step, so no request waits on a middle state
    always_comb begin
        mode_d = mode_q;
        unique case (mode_q)
            clk_gate_pkg::MODE_RUN: begin
                if (deep_sleep_req_i) begin
                    mode_d = clk_gate_pkg::MODE_DEEP;
                end else if (sleep_req_i) begin
                    mode_d = clk_gate_pkg::MODE_SLEEP;
                end
            end
            clk_gate_pkg::MODE_SLEEP: begin
                if (deep_sleep_req_i) begin
                    mode_d = clk_gate_pkg::MODE_DEEP;
                end else if (!sleep_req_i) begin
                    mode_d = clk_gate_pkg::MODE_RUN;
                end
            end
            clk_gate_pkg::MODE_DEEP: begin
                if (!deep_sleep_req_i && sleep_req_i) begin
                    mode_d = clk_gate_pkg::MODE_SLEEP;
                end else if (!deep_sleep_req_i) begin
                    mode_d = clk_gate_pkg::MODE_RUN;
                end
            end
            default: begin
                // a corrupted code falls back to running
                mode_d = clk_gate_pkg::MODE_RUN;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_q <= clk_gate_pkg::MODE_RUN;
        end else begin
            mode_q <= mode_d;
        end
    end

    // sleep entry and exit become interrupt events; both compare the
    // next mode with the current one, so each fires once per change
    assign sleep_in = (mode_d == clk_gate_pkg::MODE_SLEEP)
        && (mode_q != clk_gate_pkg::MODE_SLEEP);
    assign sleep_out = (mode_d != clk_gate_pkg::MODE_SLEEP)
        && (mode_q == clk_gate_pkg::MODE_SLEEP);

    // ---------------- enable selection ----------------
    // a unit's enable follows a mode request two edges later; software
    // that needs a unit at once must enable it before the request, since
    // the selection flop is what keeps the gate cell free of glitches
    // the chosen set drives the unit clock enables
    gate_select #(
        .UNITS(UNITS)
    ) u_gate_select (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .mode_i(mode_q),
        .auto_clock_gating_en_i(auto_clock_gating_en_i),
        .run_en_i(run_clock_gate_ctl2_i),
        .sleep_en_i(sleep_en),
        .deep_en_i(deepsleep_clock_gate_ctl2_i),
        .eff_en_o(eff_en)
    );

    // enables leave straight from the selection flops
    assign unit_clk_en_o = eff_en;

    // accesses checked against the live enables
    fault_check #(
        .UNITS(UNITS)
    ) u_fault_check (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .acc_i(periph_acc_i),
        .eff_en_i(eff_en),
        .fault_o(fault),
        .fault_unit_o(fault_unit)
    );

    assign bus_fault_o = fault;

    // ---------------- interrupt ----------------
    always_comb begin
        int_set = `INT_RESET;
        int_set[`INT_FAULT_BIT] = fault;
        int_set[`INT_SLEEP_IN_BIT] = sleep_in;
        int_set[`INT_SLEEP_OUT_BIT] = sleep_out;
    end

    // a new event outranks a write-one clear in the same cycle
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            int_status_q <= `INT_RESET;
        end else if (wr_status) begin
            int_status_q <= (int_status_q & ~pwdata_i[`INT_WIDTH-1:0])
                | int_set;
        end else begin
            int_status_q <= int_status_q | int_set;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            int_mask_q <= `INT_RESET;
        end else if (wr_mask) begin
            int_mask_q <= pwdata_i[`INT_WIDTH-1:0];
        end
    end

    // unmasked pending events
    assign int_pend = int_status_q & int_mask_q;

    // one cycle behind status so the output stays a flop
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |int_pend;
        end
    end
endmodule : sleep_mode_clock_gating
